// file: hw/eecfg_pkg.sv
// Purpose: shared constants and types for the serial eeprom configuration block
// Assumes: 20 MHz system clock, two-wire bus pins synchronised inside the block
// Notes: register fields, address patterns and timing counts
package eecfg_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 20000000;
	localparam int PROG_TIME_US = 3000;
	localparam int PROG_CYCLES = (PROG_TIME_US / 1000) * (CLK_HZ / 1000);
	// ------------------------------------------------------------
	// addressing
	// ------------------------------------------------------------
	localparam logic [3:0] DEV_FIXED = 4'hA;
	localparam logic [2:0] ADDR_SEL_RESET = 3'h0;
	localparam logic [1:0] SPACE_PROTECT = 2'h3;
	localparam logic [1:0] SPACE_ADDRCFG = 2'h2;
	localparam int WORD_ADDR_W = 14;
	// ------------------------------------------------------------
	// protection register fields
	// ------------------------------------------------------------
	localparam int PROT_EN_BIT = 3;
	localparam int PROT_SIZE_LSB = 1;
	localparam logic [7:0] PROTECT_RESET = 8'h00;
	localparam logic [1:0] SIZE_QUARTER = 2'h0;
	localparam logic [1:0] SIZE_HALF = 2'h1;
	localparam logic [1:0] SIZE_3QUARTER = 2'h2;
	localparam logic [1:0] SIZE_ALL = 2'h3;
	typedef struct packed {
		logic enable;
		logic [1:0] size;
	} protect_s;
	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_DEV = 6'b000010,
		ST_ADDR_HI = 6'b000100,
		ST_ADDR_LO = 6'b001000,
		ST_DATA = 6'b010000,
		ST_READ = 6'b100000
	} bus_state_e;
endpackage

// file: hw/eecfg_core.sv
// Purpose: two-wire slave front end with block protection and address config
// Assumes: scl/sda sampled on clk; sda is open drain (sda_oe high drives zero)
// Notes: array storage lives outside; this block issues program requests
//
// Overview of operation
// - word address top bits 11 select the block protection register
// - protection write keeps only bits 3 to 1, others ignored
// - bit 3 enables protection of the block chosen by bits 2 and 1
// - size 00 quarter, 01 half, 10 three quarters, 11 all plus config
// - protection register starts at all zeros
// - word address top bits 10 load the three bus address select bits
// - address config writes refused while protection is 0x0E pattern
// - programming interval starts at stop after write, ends within 3 ms
// - bus address is 1010, three select bits, then read/write bit
// - 14-bit word address arrives as two bytes after device address
// - during programming all bus inputs ignored, no acknowledge given
`timescale 1ns/1ps
module eecfg_core
	import eecfg_pkg::*;
#(
	parameter int PROG_CNT = PROG_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic [7:0] protect_rd,
	output logic [7:0] addr_sel_rd,
	output logic prog_busy,
	output logic prog_we,
	output logic [WORD_ADDR_W-1:0] prog_addr,
	output logic [7:0] prog_data,
	input wire logic [7:0] rd_data
);
	if (PROG_CNT < 1)
	begin : g_bad_prog_cnt
		$error("PROG_CNT must be at least one");
	end
	// ------------------------------------------------------------
	// pin synchronisers and bus events
	// ------------------------------------------------------------
	logic [1:0] scl_sync_r;
	logic [1:0] sda_sync_r;
	logic scl_d_r;
	logic sda_d_r;
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_sync_r <= 2'h3;
			sda_sync_r <= 2'h3;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end
		else
		begin
			scl_sync_r <= {scl_sync_r[0], scl_in};
			sda_sync_r <= {sda_sync_r[0], sda_in};
			scl_d_r <= scl_sync_r[1];
			sda_d_r <= sda_sync_r[1];
		end
	end
	logic scl_s;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_ev;
	logic stop_ev;
	assign scl_s = scl_sync_r[1];
	assign sda_s = sda_sync_r[1];
	assign scl_rise = scl_s && !scl_d_r;
	assign scl_fall = !scl_s && scl_d_r;
	assign start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
	assign stop_ev = scl_s && scl_d_r && !sda_d_r && sda_s;
	// ------------------------------------------------------------
	// configuration registers
	// ------------------------------------------------------------
	protect_s protect_r;
	logic [2:0] addr_sel_r;
	logic [1:0] wa_space;
	logic [WORD_ADDR_W-1:0] word_addr_r;
	assign wa_space = word_addr_r[WORD_ADDR_W-1 -: 2];
	logic all_locked;
	assign all_locked = protect_r.enable && protect_r.size == SIZE_ALL;
	// protection check for an array address
	function automatic logic is_protected(input protect_s p, input logic [WORD_ADDR_W-1:0] a);
		logic [1:0] q;
		q = a[WORD_ADDR_W-1 -: 2];
		is_protected = 1'b0;
		if (p.enable)
		begin
			unique case (p.size)
				SIZE_QUARTER: is_protected = (q == 2'h3);
				SIZE_HALF: is_protected = q[1];
				SIZE_3QUARTER: is_protected = (q != 2'h0);
				SIZE_ALL: is_protected = 1'b1;
			endcase
		end
	endfunction
	// ------------------------------------------------------------
	// bus state machine
	// ------------------------------------------------------------
	bus_state_e state_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] shift_r;
	logic ack_phase_r;
	logic wrote_r;
	logic pend_valid_r;
	logic [$clog2(PROG_CNT+1)-1:0] prog_cnt_r;
	logic byte_done;
	logic [7:0] byte_in;
	assign byte_done = scl_rise && !ack_phase_r && bit_cnt_r == 4'h7;
	assign byte_in = {shift_r[6:0], sda_s};
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r <= ST_IDLE;
			bit_cnt_r <= 4'h0;
			shift_r <= 8'h00;
			ack_phase_r <= 1'b0;
			wrote_r <= 1'b0;
			word_addr_r <= '0;
			protect_r <= protect_s'(PROTECT_RESET[PROT_EN_BIT:PROT_SIZE_LSB]);
			addr_sel_r <= ADDR_SEL_RESET;
			pend_valid_r <= 1'b0;
			prog_busy <= 1'b0;
			prog_cnt_r <= '0;
			prog_we <= 1'b0;
			prog_addr <= '0;
			prog_data <= 8'h00;
			sda_out <= 1'b1;
			sda_oe <= 1'b0;
		end
		else if (prog_busy)
		begin
			prog_we <= 1'b0;
			sda_oe <= 1'b0;
			if (prog_cnt_r == '0)
				prog_busy <= 1'b0;
			else
				prog_cnt_r <= prog_cnt_r - 1'b1;
		end
		else if (start_ev)
		begin
			state_r <= ST_DEV;
			bit_cnt_r <= 4'h0;
			ack_phase_r <= 1'b0;
			sda_oe <= 1'b0;
		end
		else if (stop_ev)
		begin
			state_r <= ST_IDLE;
			sda_oe <= 1'b0;
			if (wrote_r)
			begin
				wrote_r <= 1'b0;
				prog_busy <= 1'b1;
				prog_cnt_r <= ($clog2(PROG_CNT+1))'(PROG_CNT - 1);
			end
		end
		else
		begin
			prog_we <= 1'b0;
			if (scl_rise && !ack_phase_r)
			begin
				shift_r <= byte_in;
				bit_cnt_r <= bit_cnt_r + 4'h1;
			end
			// master nack ends the read
			if (scl_rise && ack_phase_r && state_r == ST_READ && sda_s)
				state_r <= ST_IDLE;
			// ninth clock runs from the fall after bit 8 to the next fall
			if (scl_fall && ack_phase_r)
			begin
				ack_phase_r <= 1'b0;
				bit_cnt_r <= 4'h0;
				sda_oe <= 1'b0;
				if (state_r == ST_READ)
				begin
					sda_oe <= !rd_data[7];
					shift_r <= rd_data;
					word_addr_r <= word_addr_r + 1'b1;
				end
			end
			else if (scl_fall && bit_cnt_r == 4'h8)
			begin
				ack_phase_r <= 1'b1;
				sda_oe <= 1'b0;
			end
			else if (scl_fall && state_r == ST_READ && bit_cnt_r != 4'h0)
				sda_oe <= !shift_r[7];
			if (byte_done)
			begin
				unique case (state_r)
					ST_DEV:
					begin
						if (byte_in[7:1] == {DEV_FIXED, addr_sel_r})
							state_r <= byte_in[0] ? ST_READ : ST_ADDR_HI;
						else
							state_r <= ST_IDLE;
					end
					ST_ADDR_HI:
					begin
						word_addr_r[WORD_ADDR_W-1:8] <= byte_in[WORD_ADDR_W-9:0];
						state_r <= ST_ADDR_LO;
					end
					ST_ADDR_LO:
					begin
						word_addr_r[7:0] <= byte_in;
						state_r <= ST_DATA;
					end
					ST_DATA:
					begin
						wrote_r <= 1'b1;
						if (wa_space == SPACE_PROTECT)
							protect_r <= protect_s'(byte_in[PROT_EN_BIT:PROT_SIZE_LSB]);
						else if (wa_space == SPACE_ADDRCFG)
						begin
							if (!all_locked)
								addr_sel_r <= byte_in[2:0];
						end
						else if (!is_protected(protect_r, word_addr_r))
						begin
							prog_we <= 1'b1;
							prog_addr <= word_addr_r;
							prog_data <= byte_in;
						end
						word_addr_r[5:0] <= word_addr_r[5:0] + 6'h01;
					end
					ST_READ:
						state_r <= ST_READ;
					default:
						state_r <= ST_IDLE;
				endcase
			end
			if (byte_done && state_r != ST_READ && state_r != ST_IDLE)
				pend_valid_r <= 1'b1;
			if (scl_fall && pend_valid_r)
			begin
				pend_valid_r <= 1'b0;
				sda_out <= 1'b0;
				sda_oe <= (state_r != ST_IDLE);
			end
		end
	end
	// ------------------------------------------------------------
	// register read view
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			protect_rd <= 8'h00;
			addr_sel_rd <= 8'h00;
		end
		else
		begin
			protect_rd <= {4'h0, protect_r, 1'b0};
			addr_sel_rd <= {5'h00, addr_sel_r};
		end
	end
endmodule // eecfg_core

// file: verif/eecfg_core_assertions.sv
// Purpose: port checks for eecfg_core
// Assumes: single clock, async active-low reset
// Notes: bound to every eecfg_core
`timescale 1ns/1ps
module eecfg_core_assertions
	import eecfg_pkg::*;
#(
	parameter int PROG_CNT = PROG_CYCLES
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe,
	input wire logic [7:0] protect_rd,
	input wire logic [7:0] addr_sel_rd,
	input wire logic prog_busy,
	input wire logic prog_we,
	input wire logic [WORD_ADDR_W-1:0] prog_addr,
	input wire logic [7:0] prog_data,
	input wire logic [7:0] rd_data
);
	logic [15:0] cnt_r;
	logic hit;
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
			cnt_r <= 16'h0000;
		else
			cnt_r <= prog_busy ? cnt_r + 16'h0001 : 16'h0000;
	assign hit = protect_rd[3] && (prog_addr[13:12] >= 2'h3 - protect_rd[2:1]);
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_n);
	sequence locked_s;
		protect_rd == 8'h0E;
	endsequence
	a_reset_zero: assert property ($rose(rst_n) |-> protect_rd == 8'h00 && addr_sel_rd == 8'h00)
		else $error("config not zero after reset");
	a_prot_view: assert property (protect_rd[7:4] == 4'h0 && !protect_rd[0])
		else $error("protect view unused bits set");
	a_sel_view: assert property (addr_sel_rd[7:3] == 5'h00)
		else $error("select view unused bits set");
	a_prot_block: assert property (prog_we |-> !hit)
		else $error("protected byte programmed");
	a_sel_locked: assert property (locked_s |=> $stable(addr_sel_rd))
		else $error("select changed while locked");
	a_busy_len: assert property ($fell(prog_busy) |-> cnt_r == PROG_CNT)
		else $error("busy length wrong");
	a_busy_mute: assert property (prog_busy |-> !sda_oe)
		else $error("ack while busy");
	a_busy_nowe: assert property (prog_busy |-> !prog_we)
		else $error("program pulse while busy");
	a_ack_low: assert property (sda_oe |-> !sda_out)
		else $error("sda driven high");
	a_busy_quiet: assert property (prog_busy |=> $stable(protect_rd) && $stable(addr_sel_rd))
		else $error("config changed while busy");
endmodule // eecfg_core_assertions
bind eecfg_core eecfg_core_assertions #(.PROG_CNT(PROG_CNT)) chk_i (.clk(clk), .rst_n(rst_n),
	.scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
	.protect_rd(protect_rd), .addr_sel_rd(addr_sel_rd), .prog_busy(prog_busy),
	.prog_we(prog_we), .prog_addr(prog_addr), .prog_data(prog_data), .rd_data(rd_data));

// file: verif/bus_ctl.sv
// Purpose: two-wire bus controller model
// Assumes: open-drain sda with pull-up, scl idle high
// Notes: four clk per third of a bit
`timescale 1ns/1ps
module bus_ctl
(
	input wire logic clk,
	input wire logic sda_line,
	output logic scl,
	output logic sda
);
	initial
	begin
		scl = 1'b1;
		sda = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic bit_x(input logic b, output logic r);
		sda <= b;
		wt(4);
		scl <= 1'b1;
		wt(4);
		r = sda_line;
		scl <= 1'b0;
		wt(4);
	endtask
	task automatic start_c();
		sda <= 1'b0;
		wt(4);
		scl <= 1'b0;
	endtask
	task automatic stop_c();
		sda <= 1'b0;
		wt(4);
		scl <= 1'b1;
		wt(4);
		sda <= 1'b1;
		wt(4);
	endtask
	// start, address byte, one byte read, no ack, stop
	task automatic rd(input logic [7:0] dev, output logic [7:0] v, output logic ok);
		logic r;
		start_c();
		for (int i = 7; i >= 0; i--)
			bit_x(dev[i], r);
		bit_x(1'b1, r);
		ok = ~r;
		for (int i = 7; i >= 0; i--)
		begin
			bit_x(1'b1, r);
			v[i] = r;
		end
		bit_x(1'b1, r);
		stop_c();
	endtask
	// start, four bytes with ack slots, stop
	task automatic wr(input logic [31:0] w, output logic ok);
		logic r;
		ok = 1'b1;
		start_c();
		for (int i = 31; i >= 0; i--)
		begin
			bit_x(w[i], r);
			if (i % 8 == 0)
			begin
				bit_x(1'b1, r);
				ok = ok & ~r;
			end
		end
		stop_c();
	endtask
endmodule // bus_ctl

// file: verif/test_eeprom_block_protect_addr_config.sv
// Purpose: self-checking bench for eecfg_core
// Assumes: PROG_CNT of 20
// Notes: program pulses checked against a queue
`timescale 1ns/1ps
module test_eeprom_block_protect_addr_config;
	logic clk, rst_n, scl, sda, sda_out, sda_oe, prog_busy, prog_we, ok;
	wire sda_line;
	logic [7:0] protect_rd, addr_sel_rd, prog_data, rd_data, d;
	logic [13:0] prog_addr;
	logic [2:0] sel;
	logic [21:0] q[$];
	logic [21:0] e;
	int seed, n_fail, total_checks, cyc;
	assign sda_line = sda & ~(sda_oe & ~sda_out);
	eecfg_core #(.PROG_CNT(20)) uut (.clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .protect_rd(protect_rd), .addr_sel_rd(addr_sel_rd),
		.prog_busy(prog_busy), .prog_we(prog_we), .prog_addr(prog_addr),
		.prog_data(prog_data), .rd_data(rd_data));
	bus_ctl ctl (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(sda));
	initial
	begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic chk(input string nm, input logic [21:0] x, input logic [21:0] g);
		total_checks++;
		if (g !== x)
		begin
			n_fail++;
			$display("unexpected %s exp %0h got %0h", nm, x, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(negedge clk)
		if (prog_we === 1'b1)
		begin
			e = (q.size() > 0) ? q.pop_front() : 22'h3FFFFF;
			chk("prog", e, {prog_addr, prog_data});
		end
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			n_fail++;
			print_verdict();
		end
	end
	initial
	begin
		seed = 84;
		rst_n = 1'b0;
		rd_data = 8'h00;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd_data <= $random(seed);
		ctl.wt(4);
		chk("protect", 8'h00, protect_rd);
		chk("sel", 8'h00, addr_sel_rd);
		$display("test reset done");
		for (int s = 0; s < 4; s++)
		begin
			ctl.wr({24'hA0F000, 4'hF, 1'b1, 2'(s), 1'b1}, ok);
			ctl.wt(30);
			chk("protect", {4'h0, 1'b1, 2'(s), 1'b0}, protect_rd);
		end
		ctl.wr(32'hA0A00005, ok);
		ctl.wt(30);
		chk("sel", 8'h00, addr_sel_rd);
		$display("test protect done");
		ctl.wr(32'hA0F0000C, ok);
		ctl.wt(30);
		d = $random(seed);
		q.push_back({14'h0000, d});
		ctl.wr({24'hA00000, d}, ok);
		ctl.wt(8);
		ctl.wr(32'hA0100033, ok);
		chk("ack", 1'b0, ok);
		ctl.wt(30);
		ctl.wr(32'hA0100033, ok);
		chk("ack", 1'b1, ok);
		ctl.wt(30);
		$display("test array done");
		ctl.wr(32'hA0F00000, ok);
		ctl.wt(30);
		sel = $random(seed);
		sel[0] = 1'b1;
		ctl.wr({24'hA0A000, 5'h00, sel}, ok);
		ctl.wt(30);
		chk("sel", {5'h00, sel}, addr_sel_rd);
		d = $random(seed);
		q.push_back({14'h0512, d});
		ctl.wr({4'hA, sel, 1'b0, 16'h0512, d}, ok);
		ctl.wt(30);
		ctl.wr(32'hA0000011, ok);
		chk("ack", 1'b0, ok);
		ctl.wt(30);
		chk("queue", 22'h0, q.size());
		$display("test address done");
		rd_data <= $random(seed);
		ctl.rd({4'hA, sel, 1'b1}, d, ok);
		chk("read", {1'b1, rd_data}, {ok, d});
		ctl.wt(30);
		$display("test read done");
		ctl.wr({4'hA, sel, 1'b0, 24'h300004}, ok);
		ctl.wt(30);
		chk("protect", 8'h04, protect_rd);
		rst_n <= 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		ctl.wt(4);
		chk("protect", 8'h00, protect_rd);
		chk("sel", 8'h00, addr_sel_rd);
		$display("test mid reset done");
		print_verdict();
	end
endmodule // test_eeprom_block_protect_addr_config
